// ===== logic/ppaf_addr_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppaf_defs.svh"
module ppaf_addr_match
  import ppaf_pkg::*;
  (
  ppaf_match_if.matcher m
  );

  // Pure compare; the caller registers whatever it derives from the result.
  always_comb
  begin
    m.is_ptp = (m.enables[`PPAF_EN_PRI]  && (m.dest == `PPAF_ADDR_PRI))
            || (m.enables[`PPAF_EN_ALT1] && (m.dest == `PPAF_ADDR_ALT1))
            || (m.enables[`PPAF_EN_ALT2] && (m.dest == `PPAF_ADDR_ALT2))
            || (m.enables[`PPAF_EN_ALT3] && (m.dest == `PPAF_ADDR_ALT3))
            || (m.enables[`PPAF_EN_AUX]  && (m.dest == m.aux));
  end
endmodule // ppaf_addr_match
`default_nettype wire

// ===== logic/ppaf_defs.svh
`ifndef PPAF_DEFS_SVH
`define PPAF_DEFS_SVH

`define PPAF_AXI_ADDR_W      12
`define PPAF_NUM_CH          4
`define PPAF_NUM_ADDR        5

`define PPAF_OFF_AUX_HI      12'h18C
`define PPAF_OFF_AUX_LO      12'h190
`define PPAF_OFF_CFG         12'h194
`define PPAF_OFF_INT_STS     12'h198
`define PPAF_OFF_INT_MASK    12'h19C

`define PPAF_BIT_P2_ALT2     28
`define PPAF_BIT_P2_ALT3     27
`define PPAF_BIT_P2_AUX      26
`define PPAF_BIT_P2_LOCK_RX  25
`define PPAF_BIT_P2_LOCK_TX  24
`define PPAF_BIT_P1_MASTER   23
`define PPAF_BIT_P1_PRI      22
`define PPAF_BIT_P1_ALT1     21
`define PPAF_BIT_P1_ALT2     20
`define PPAF_BIT_P1_ALT3     19
`define PPAF_BIT_P1_AUX      18

`define PPAF_CFG_RST         32'h03400000
`define PPAF_CFG_MASK        32'h1FFC0000
`define PPAF_AUX_HI_RST      16'h0000
`define PPAF_AUX_LO_RST      32'h00000000
`define PPAF_INT_RST         4'h0

`define PPAF_EN_PRI          0
`define PPAF_EN_ALT1         1
`define PPAF_EN_ALT2         2
`define PPAF_EN_ALT3         3
`define PPAF_EN_AUX          4

`define PPAF_ADDR_PRI        48'h01005E000181
`define PPAF_ADDR_ALT1       48'h01005E000182
`define PPAF_ADDR_ALT2       48'h01005E000183
`define PPAF_ADDR_ALT3       48'h01005E000184

`define PPAF_MSG_SYNC        4'h0
`define PPAF_MSG_DELAY_REQ   4'h1

`define PPAF_CH_P1_RX        0
`define PPAF_CH_P1_TX        1
`define PPAF_CH_P2_RX        2
`define PPAF_CH_P2_TX        3

`define PPAF_RESP_OKAY       2'h0
`define PPAF_RESP_SLVERR     2'h2
`endif

// ===== logic/ppaf_match_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppaf_match_if
  import ppaf_pkg::*;
  ();
  logic [47:0]    dest;
  ppaf_addr_en_t  enables;
  logic [47:0]    aux;
  logic           is_ptp;

  modport matcher (input dest, input enables, input aux, output is_ptp);
  modport requester (output dest, output enables, output aux, input is_ptp);
endinterface
`default_nettype wire

// ===== logic/ppaf_pkg.sv
`include "ppaf_defs.svh"
package ppaf_pkg;
  typedef logic [`PPAF_NUM_ADDR-1:0] ppaf_addr_en_t;

  typedef struct packed {
    logic                         awready;
    logic                         wready;
    logic                         aw_have;
    logic                         w_have;
    logic [`PPAF_AXI_ADDR_W-1:0]  awaddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic [31:0]                  cfg;
    logic [15:0]                  aux_hi;
    logic [31:0]                  aux_lo;
    logic [`PPAF_NUM_CH-1:0]      int_sts;
    logic [`PPAF_NUM_CH-1:0]      int_mask;
    logic                         irq;
    logic [`PPAF_NUM_CH-1:0]      capture;
    logic [`PPAF_NUM_CH-1:0]      ptp_seen;
  } ppaf_state_t;
endpackage

// ===== logic/ppaf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppaf_defs.svh"
module ppaf_top
  import ppaf_pkg::*;
  (
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  input  wire logic                                 s_axi_awvalid,
  output var  logic                                 s_axi_awready,
  input  wire logic [`PPAF_AXI_ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic                                 s_axi_wvalid,
  output var  logic                                 s_axi_wready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  output var  logic                                 s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  output var  logic [1:0]                           s_axi_bresp,
  input  wire logic                                 s_axi_arvalid,
  output var  logic                                 s_axi_arready,
  input  wire logic [`PPAF_AXI_ADDR_W-1:0]          s_axi_araddr,
  output var  logic                                 s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  output var  logic [31:0]                          s_axi_rdata,
  output var  logic [1:0]                           s_axi_rresp,
  input  wire logic [`PPAF_NUM_CH-1:0]              frame_valid,
  input  wire logic [`PPAF_NUM_CH-1:0][47:0]        frame_dest,
  input  wire logic [`PPAF_NUM_CH-1:0][3:0]         frame_msg_type,
  output var  logic [`PPAF_NUM_CH-1:0]              capture_strobe,
  output var  logic [`PPAF_NUM_CH-1:0]              ptp_frame,
  output var  logic                                 irq
  );

  ppaf_state_t                  s_r;
  ppaf_state_t                  s_nxt;
  logic [`PPAF_NUM_CH-1:0]      is_ptp;
  logic [`PPAF_NUM_CH-1:0]      cap_hit;
  logic [47:0]                  aux_addr;

  function automatic logic reg_hit(input logic [`PPAF_AXI_ADDR_W-1:0] addr,
                                   input logic [`PPAF_AXI_ADDR_W-1:0] off);
    reg_hit = (addr[`PPAF_AXI_ADDR_W-1:2] == off[`PPAF_AXI_ADDR_W-1:2]);
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Per-channel address enables; port 2 primary and alternate one are not part of this block.
  function automatic ppaf_addr_en_t chan_enables(input int ch, input logic [31:0] cfg);
    if (ch < `PPAF_CH_P2_RX)
      chan_enables = {cfg[`PPAF_BIT_P1_AUX], cfg[`PPAF_BIT_P1_ALT3], cfg[`PPAF_BIT_P1_ALT2],
                      cfg[`PPAF_BIT_P1_ALT1], cfg[`PPAF_BIT_P1_PRI]};
    else
      chan_enables = {cfg[`PPAF_BIT_P2_AUX], cfg[`PPAF_BIT_P2_ALT3], cfg[`PPAF_BIT_P2_ALT2], 1'b0, 1'b0};
  endfunction

  // Which event message a channel timestamps: by role for port 1; port 2 channels take both Sync and Delay_Req.
  function automatic logic wants_capture(input int ch, input logic [3:0] msg, input logic master);
    logic is_sync;
    logic is_dreq;
    is_sync = (msg == `PPAF_MSG_SYNC);
    is_dreq = (msg == `PPAF_MSG_DELAY_REQ);
    if (ch == `PPAF_CH_P1_RX)
      wants_capture = master ? is_dreq : is_sync;
    else if (ch == `PPAF_CH_P1_TX)
      wants_capture = master ? is_sync : is_dreq;
    else
      wants_capture = is_sync || is_dreq;
  endfunction

  assign aux_addr = {s_r.aux_hi, s_r.aux_lo};

  for (genvar g = 0; g < `PPAF_NUM_CH; g++)
  begin : g_chan
    ppaf_match_if mif ();
    logic         wanted;
    logic         locked;

    assign mif.dest    = frame_dest[g];
    assign mif.enables = chan_enables(g, s_r.cfg);
    assign mif.aux     = aux_addr;
    assign is_ptp[g]   = mif.is_ptp;

    ppaf_addr_match u_match (
      .m (mif.matcher)
    );

    assign wanted = wants_capture(g, frame_msg_type[g], s_r.cfg[`PPAF_BIT_P1_MASTER]);

    // Only port 2 has locks here; a pending flag then guards the stored stamp from a second capture.
    if (g == `PPAF_CH_P2_RX)
    begin : g_lock_rx
      assign locked = s_r.cfg[`PPAF_BIT_P2_LOCK_RX] && s_r.int_sts[g];
    end
    else if (g == `PPAF_CH_P2_TX)
    begin : g_lock_tx
      assign locked = s_r.cfg[`PPAF_BIT_P2_LOCK_TX] && s_r.int_sts[g];
    end
    else
    begin : g_nolock
      assign locked = 1'b0;
    end

    assign cap_hit[g] = frame_valid[g] && is_ptp[g] && wanted && !locked;
  end

  always_comb
  begin
    logic [31:0] merged;
    logic [31:0] clr;
    merged = 32'h00000000;
    clr    = 32'h00000000;
    s_nxt  = s_r;

    s_nxt.capture  = cap_hit;
    s_nxt.ptp_seen = frame_valid & is_ptp;

    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.awaddr  = s_axi_awaddr;
      s_nxt.aw_have = 1'b1;
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
      s_nxt.w_have = 1'b1;
      s_nxt.wready = 1'b0;
    end

    if (s_r.aw_have && s_r.w_have && !s_r.bvalid)
    begin
      s_nxt.bresp = `PPAF_RESP_OKAY;
      if (reg_hit(s_r.awaddr, `PPAF_OFF_CFG))
      begin
        merged    = (s_r.cfg & ~strb_mask(s_r.wstrb)) | (s_r.wdata & strb_mask(s_r.wstrb));
        s_nxt.cfg = merged & `PPAF_CFG_MASK;
      end
      else if (reg_hit(s_r.awaddr, `PPAF_OFF_AUX_HI))
      begin
        merged       = ({16'h0000, s_r.aux_hi} & ~strb_mask(s_r.wstrb)) | (s_r.wdata & strb_mask(s_r.wstrb));
        s_nxt.aux_hi = merged[15:0];
      end
      else if (reg_hit(s_r.awaddr, `PPAF_OFF_AUX_LO))
      begin
        merged       = (s_r.aux_lo & ~strb_mask(s_r.wstrb)) | (s_r.wdata & strb_mask(s_r.wstrb));
        s_nxt.aux_lo = merged;
      end
      else if (reg_hit(s_r.awaddr, `PPAF_OFF_INT_STS))
      begin
        clr           = s_r.wdata & strb_mask(s_r.wstrb);
        s_nxt.int_sts = s_r.int_sts & ~clr[`PPAF_NUM_CH-1:0];
      end
      else if (reg_hit(s_r.awaddr, `PPAF_OFF_INT_MASK))
      begin
        merged         = ({28'h0000000, s_r.int_mask} & ~strb_mask(s_r.wstrb))
                       | (s_r.wdata & strb_mask(s_r.wstrb));
        s_nxt.int_mask = merged[`PPAF_NUM_CH-1:0];
      end
      else
      begin
        s_nxt.bresp = `PPAF_RESP_SLVERR;
      end
      s_nxt.bvalid  = 1'b1;
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
    end

    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // A capture in the same cycle as a write-one-to-clear keeps its flag set.
    s_nxt.int_sts = s_nxt.int_sts | cap_hit;

    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = `PPAF_RESP_OKAY;
      if (reg_hit(s_axi_araddr, `PPAF_OFF_CFG))
        s_nxt.rdata = s_r.cfg;
      else if (reg_hit(s_axi_araddr, `PPAF_OFF_AUX_HI))
        s_nxt.rdata = {16'h0000, s_r.aux_hi};
      else if (reg_hit(s_axi_araddr, `PPAF_OFF_AUX_LO))
        s_nxt.rdata = s_r.aux_lo;
      else if (reg_hit(s_axi_araddr, `PPAF_OFF_INT_STS))
        s_nxt.rdata = {28'h0000000, s_r.int_sts};
      else if (reg_hit(s_axi_araddr, `PPAF_OFF_INT_MASK))
        s_nxt.rdata = {28'h0000000, s_r.int_mask};
      else
      begin
        s_nxt.rdata = 32'h00000000;
        s_nxt.rresp = `PPAF_RESP_SLVERR;
      end
    end
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end

    s_nxt.irq = |(s_nxt.int_sts & s_nxt.int_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r          <= '0;
      s_r.awready  <= 1'b1;
      s_r.wready   <= 1'b1;
      s_r.arready  <= 1'b1;
      s_r.cfg      <= `PPAF_CFG_RST;
      s_r.aux_hi   <= `PPAF_AUX_HI_RST;
      s_r.aux_lo   <= `PPAF_AUX_LO_RST;
      s_r.int_sts  <= `PPAF_INT_RST;
      s_r.int_mask <= `PPAF_INT_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready  = s_r.awready;
  assign s_axi_wready   = s_r.wready;
  assign s_axi_bvalid   = s_r.bvalid;
  assign s_axi_bresp    = s_r.bresp;
  assign s_axi_arready  = s_r.arready;
  assign s_axi_rvalid   = s_r.rvalid;
  assign s_axi_rdata    = s_r.rdata;
  assign s_axi_rresp    = s_r.rresp;
  assign capture_strobe = s_r.capture;
  assign ptp_frame      = s_r.ptp_seen;
  assign irq            = s_r.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_cfg_reset_value: assert property (
    @(posedge aclk) disable iff (1'b0) !aresetn |=> (s_r.cfg == `PPAF_CFG_RST))
    else $error("Configuration did not take its reset value.");

  chk_p2_alt_two: assert property (
    frame_valid[2] && frame_dest[2] == `PPAF_ADDR_ALT2 && s_r.cfg[28] && frame_msg_type[2] == `PPAF_MSG_SYNC
    && !(s_r.cfg[25] && s_r.int_sts[2]) |=> capture_strobe[2] ##1 (!capture_strobe[2] || $past(frame_valid[2])))
    else $error("Port 2 receive missed a frame to alternate address two.");

  chk_p2_alt_three: assert property (
    frame_valid[3] && frame_dest[3] == `PPAF_ADDR_ALT3 && s_r.cfg[27]
    && frame_msg_type[3] == `PPAF_MSG_DELAY_REQ && !s_r.int_sts[3] |=> capture_strobe[3] && s_r.int_sts[3])
    else $error("Port 2 transmit missed a frame to alternate address three.");

  chk_p2_aux_match: assert property (
    frame_valid[2] && frame_dest[2] == {s_r.aux_hi, s_r.aux_lo} && s_r.cfg[26] |=> ptp_frame[2])
    else $error("Port 2 did not recognise the auxiliary address.");

  chk_p2_rx_lock: assert property (
    s_r.cfg[25] && s_r.int_sts[2] && !(s_r.aw_have && s_r.w_have && !s_r.bvalid
    && reg_hit(s_r.awaddr, `PPAF_OFF_INT_STS) && s_r.wdata[2] && s_r.wstrb[0])
    |=> !capture_strobe[2] && s_r.int_sts[2])
    else $error("Port 2 receive capture overwrote a pending stamp.");

  chk_p2_tx_lock: assert property (
    s_r.cfg[24] && s_r.int_sts[3] |=> !capture_strobe[3])
    else $error("Port 2 transmit capture overwrote a pending stamp.");

  chk_p1_master_role: assert property (
    frame_valid[1] && frame_dest[1] == `PPAF_ADDR_PRI && s_r.cfg[22] && s_r.cfg[23]
    |-> ##1 (capture_strobe[1] == ($past(frame_msg_type[1]) == `PPAF_MSG_SYNC)))
    else $error("Port 1 master captured the wrong transmit message.");

  chk_p1_slave_role: assert property (
    frame_valid[0] && frame_dest[0] == `PPAF_ADDR_PRI && s_r.cfg[22] && !s_r.cfg[23]
    |=> capture_strobe[0] == ($past(frame_msg_type[0]) == `PPAF_MSG_SYNC))
    else $error("Port 1 slave captured the wrong receive message.");

  chk_p1_alt_one: assert property (
    frame_valid[0] && frame_dest[0] == `PPAF_ADDR_ALT1 && s_r.cfg[21] |=> ptp_frame[0])
    else $error("Port 1 did not recognise alternate address one.");

  chk_p1_alt_two_three: assert property (
    frame_valid[1] && ((frame_dest[1] == `PPAF_ADDR_ALT2 && s_r.cfg[20])
    || (frame_dest[1] == `PPAF_ADDR_ALT3 && s_r.cfg[19])) |=> ptp_frame[1])
    else $error("Port 1 did not recognise alternate address two or three.");

  chk_p1_aux_match: assert property (
    frame_valid[1] && frame_dest[1] == {s_r.aux_hi, s_r.aux_lo} && s_r.cfg[18] |=> ptp_frame[1])
    else $error("Port 1 did not recognise the auxiliary address.");

  chk_disabled_no_match: assert property (
    frame_valid[0] && frame_dest[0] == `PPAF_ADDR_PRI && !s_r.cfg[22] && !s_r.cfg[18] |=> !capture_strobe[0])
    else $error("Port 1 captured a frame whose address is disabled.");

  chk_aux_write_used: assert property (
    s_r.aw_have && s_r.w_have && !s_r.bvalid && reg_hit(s_r.awaddr, `PPAF_OFF_AUX_LO) && s_r.wstrb == 4'hF
    |=> s_r.aux_lo == $past(s_r.wdata) && s_axi_bvalid)
    else $error("Auxiliary address write did not take effect.");

  chk_aux_hi_write: assert property (
    s_r.aw_have && s_r.w_have && !s_r.bvalid && reg_hit(s_r.awaddr, `PPAF_OFF_AUX_HI) && s_r.wstrb == 4'hF
    |=> s_r.aux_hi == $past(s_r.wdata[15:0]))
    else $error("Auxiliary upper half write did not take effect.");

  chk_p1_primary_seen: assert property (
    frame_valid[0] && frame_dest[0] == `PPAF_ADDR_PRI && s_r.cfg[22] |=> ptp_frame[0])
    else $error("Port 1 did not recognise the primary address.");

  chk_p1_master_rx: assert property (
    frame_valid[0] && frame_dest[0] == `PPAF_ADDR_PRI && s_r.cfg[22] && s_r.cfg[23]
    |=> capture_strobe[0] == ($past(frame_msg_type[0]) == `PPAF_MSG_DELAY_REQ))
    else $error("Port 1 master captured the wrong receive message.");

  chk_p1_slave_tx: assert property (
    frame_valid[1] && frame_dest[1] == `PPAF_ADDR_PRI && s_r.cfg[22] && !s_r.cfg[23]
    |=> capture_strobe[1] == ($past(frame_msg_type[1]) == `PPAF_MSG_DELAY_REQ))
    else $error("Port 1 slave captured the wrong transmit message.");

  chk_p2_rx_disabled: assert property (
    frame_valid[2] && !s_r.cfg[28] && !s_r.cfg[27] && !s_r.cfg[26] |=> !ptp_frame[2] && !capture_strobe[2])
    else $error("Port 2 receive matched with every address disabled.");

  chk_p2_tx_disabled: assert property (
    frame_valid[3] && !s_r.cfg[28] && !s_r.cfg[27] && !s_r.cfg[26] |=> !ptp_frame[3] && !capture_strobe[3])
    else $error("Port 2 transmit matched with every address disabled.");

  chk_p2_rx_pending: assert property (
    capture_strobe[2] |-> s_r.int_sts[2])
    else $error("Port 2 receive capture left no pending flag.");

  chk_p2_tx_pending: assert property (
    capture_strobe[3] |-> s_r.int_sts[3])
    else $error("Port 2 transmit capture left no pending flag.");

  cov_p1_master_capture: cover property (s_r.cfg[23] && capture_strobe[1]);
  cov_p2_lock_block: cover property (frame_valid[2] && s_r.int_sts[2] && s_r.cfg[25] && is_ptp[2]);
  cov_irq_raised: cover property (!irq ##1 irq);
  cov_write_response: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `PPAF_RESP_OKAY);
  cov_p2_tx_alt_three: cover property (frame_valid[3] && frame_dest[3] == `PPAF_ADDR_ALT3 && s_r.cfg[27]);
endmodule // ppaf_top
`default_nettype wire

// ===== test/ppaf_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppaf_defs.svh"
module ppaf_bench
  import ppaf_pkg::*;
  ;
  logic                             aclk;
  logic                             aresetn;
  logic                             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                             s_axi_rvalid, s_axi_rready, irq;
  logic [`PPAF_AXI_ADDR_W-1:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]                      s_axi_wdata, s_axi_rdata;
  logic [3:0]                       s_axi_wstrb;
  logic [1:0]                       s_axi_bresp, s_axi_rresp;
  logic [`PPAF_NUM_CH-1:0]          frame_valid, capture_strobe, ptp_frame;
  logic [`PPAF_NUM_CH-1:0][47:0]    frame_dest;
  logic [`PPAF_NUM_CH-1:0][3:0]     frame_msg_type;
  int                               miscompares;
  int                               samples_checked;
  localparam logic [47:0]           AUX = 48'h0A1B2C3D4E5F;

  ppaf_frame_src i_ppaf_frame_src (.aclk(aclk), .frame_valid(frame_valid), .frame_dest(frame_dest),
    .frame_msg_type(frame_msg_type));

  ppaf_top i_ppaf_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .frame_valid(frame_valid),
    .frame_dest(frame_dest), .frame_msg_type(frame_msg_type), .capture_strobe(capture_strobe),
    .ptp_frame(ptp_frame), .irq(irq));

  always #5 aclk = ~aclk;

  task automatic end_of_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    begin
      samples_checked++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task automatic guard(input int n);
    begin
      if (n >= 100)
      begin
        miscompares++;
        $display("unexpected handshake wait: expected answer seen none");
        end_of_test;
      end
    end
  endtask

  // Ready and valid are registered, so their value at the falling edge is what the next rising edge takes.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw_p, w_p, hit_aw, hit_w, got;
    begin
      n = 0;
      aw_p = 1'b1;
      w_p = 1'b1;
      got = 1'b0;
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      while (aw_p || w_p)
      begin
        @(negedge aclk);
        hit_aw = s_axi_awready;
        hit_w = s_axi_wready;
        @(posedge aclk);
        if (aw_p && hit_aw)
          s_axi_awvalid <= 1'b0;
        if (w_p && hit_w)
          s_axi_wvalid <= 1'b0;
        aw_p = aw_p && !hit_aw;
        w_p = w_p && !hit_w;
        n++;
        guard(n);
      end
      s_axi_bready <= 1'b1;
      while (!got)
      begin
        @(negedge aclk);
        got = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge aclk);
        n++;
        guard(n);
      end
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic hit, got;
    begin
      n = 0;
      hit = 1'b0;
      got = 1'b0;
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      while (!hit)
      begin
        @(negedge aclk);
        hit = s_axi_arready;
        @(posedge aclk);
        n++;
        guard(n);
      end
      s_axi_arvalid <= 1'b0;
      s_axi_rready  <= 1'b1;
      while (!got)
      begin
        @(negedge aclk);
        got = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        n++;
        guard(n);
      end
      s_axi_rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    begin
      axi_write(a, d, r);
      chk("bresp", r, `PPAF_RESP_OKAY);
    end
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    begin
      axi_read(a, d, r);
      chk("rresp", r, `PPAF_RESP_OKAY);
      chk(what, d, exp);
    end
  endtask

  task automatic frame_chk(input int ch, input logic [47:0] d, input logic [3:0] t, input logic ep, input logic ec);
    begin
      i_ppaf_frame_src.send(ch, d, t);
      #1;
      chk("ptp_frame", ptp_frame[ch], ep);
      chk("capture_strobe", capture_strobe[ch], ec);
    end
  endtask

  task automatic irq_chk(input logic exp);
    begin
      @(posedge aclk);
      #1;
      chk("irq", irq, exp);
    end
  endtask

  task automatic scn_regs;
    logic [31:0] d;
    logic [1:0]  r;
    begin
      rd_chk("config reset", `PPAF_OFF_CFG, 32'h03400000);
      rd_chk("aux upper reset", `PPAF_OFF_AUX_HI, 32'h00000000);
      rd_chk("aux lower reset", `PPAF_OFF_AUX_LO, 32'h00000000);
      rd_chk("status reset", `PPAF_OFF_INT_STS, 32'h00000000);
      rd_chk("mask reset", `PPAF_OFF_INT_MASK, 32'h00000000);
      axi_read(12'h000, d, r);
      chk("unmapped rresp", r, `PPAF_RESP_SLVERR);
      chk("unmapped rdata", d, 32'h00000000);
      axi_write(12'h004, 32'hFFFFFFFF, r);
      chk("unmapped bresp", r, `PPAF_RESP_SLVERR);
      wr(`PPAF_OFF_CFG, 32'hFFFFFFFF);
      rd_chk("config stored bits", `PPAF_OFF_CFG, 32'h1FFC0000);
      wr(`PPAF_OFF_AUX_HI, 32'h00000A1B);
      wr(`PPAF_OFF_AUX_LO, 32'h2C3D4E5F);
      rd_chk("aux upper", `PPAF_OFF_AUX_HI, 32'h00000A1B);
      rd_chk("aux lower", `PPAF_OFF_AUX_LO, 32'h2C3D4E5F);
    end
  endtask

  // Channel 0 is port 1 receive, channel 1 port 1 transmit; type 0 is Sync, type 1 Delay_Req.
  task automatic scn_port1_roles;
    logic ec;
    begin
      for (int m = 0; m < 2; m++)
      begin
        wr(`PPAF_OFF_CFG, 32'h03400000 | (32'(m) << 23));
        for (int ch = 0; ch < 2; ch++)
          for (int t = 0; t < 2; t++)
          begin
            ec = ((ch == 0) == (t == 0)) ^ (m == 1);
            frame_chk(ch, 48'h01005E000181, 4'(t), 1'b1, ec);
          end
      end
      wr(`PPAF_OFF_CFG, 32'h03400000);
      frame_chk(0, 48'h01005E000185, 4'h0, 1'b0, 1'b0);
    end
  endtask

  task automatic scn_addr_enables;
    int          bits [8] = '{22, 21, 20, 19, 18, 28, 27, 26};
    logic [47:0] dst [8] = '{48'h01005E000181, 48'h01005E000182, 48'h01005E000183, 48'h01005E000184, AUX,
                             48'h01005E000183, 48'h01005E000184, AUX};
    int          chs [8] = '{0, 0, 1, 1, 1, 2, 3, 2};
    int          ch;
    logic [3:0]  t;
    begin
      for (int i = 0; i < 8; i++)
      begin
        ch = chs[i];
        // Transmit channels carry Delay_Req, which a port 1 slave and port 2 both timestamp.
        t = (ch % 2 == 1) ? 4'h1 : 4'h0;
        wr(`PPAF_OFF_CFG, 32'h03000000);
        frame_chk(ch, dst[i], t, 1'b0, 1'b0);
        wr(`PPAF_OFF_INT_STS, 32'h0000000F);
        wr(`PPAF_OFF_CFG, 32'h03000000 | (32'h1 << bits[i]));
        frame_chk(ch, dst[i], t, 1'b1, 1'b1);
        wr(`PPAF_OFF_CFG, 32'h03000000);
        frame_chk(ch, dst[i], t, 1'b0, 1'b0);
      end
    end
  endtask

  task automatic scn_locks_irq;
    begin
      wr(`PPAF_OFF_INT_STS, 32'h0000000F);
      wr(`PPAF_OFF_INT_MASK, 32'h00000004);
      wr(`PPAF_OFF_CFG, 32'h07400000);
      frame_chk(2, AUX, 4'h0, 1'b1, 1'b1);
      irq_chk(1'b1);
      frame_chk(2, AUX, 4'h1, 1'b1, 1'b0);
      frame_chk(3, AUX, 4'h0, 1'b1, 1'b1);
      frame_chk(3, AUX, 4'h1, 1'b1, 1'b0);
      rd_chk("status", `PPAF_OFF_INT_STS, 32'h0000000C);
      wr(`PPAF_OFF_INT_MASK, 32'h00000000);
      irq_chk(1'b0);
      wr(`PPAF_OFF_INT_MASK, 32'h00000004);
      irq_chk(1'b1);
      wr(`PPAF_OFF_INT_STS, 32'h00000004);
      irq_chk(1'b0);
      rd_chk("status after clear", `PPAF_OFF_INT_STS, 32'h00000008);
      // With both locks cleared a pending capture no longer protects the stored values.
      wr(`PPAF_OFF_CFG, 32'h04400000);
      frame_chk(3, AUX, 4'h1, 1'b1, 1'b1);
      frame_chk(2, AUX, 4'h0, 1'b1, 1'b1);
      frame_chk(2, AUX, 4'h1, 1'b1, 1'b1);
      irq_chk(1'b1);
    end
  endtask

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = '0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = '0;
    s_axi_rready = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    scn_regs();
    scn_port1_roles();
    scn_addr_enables();
    scn_locks_irq();
    end_of_test();
  end
endmodule // ppaf_bench
`default_nettype wire

// ===== test/ppaf_frame_src.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppaf_defs.svh"
module ppaf_frame_src
  import ppaf_pkg::*;
  (
  input  wire logic                          aclk,
  output var  logic [`PPAF_NUM_CH-1:0]       frame_valid,
  output var  logic [`PPAF_NUM_CH-1:0][47:0] frame_dest,
  output var  logic [`PPAF_NUM_CH-1:0][3:0]  frame_msg_type
  );
  initial
  begin
    frame_valid    = '0;
    frame_dest     = '0;
    frame_msg_type = '0;
  end

  // Between frames the header fields carry the inverse of the last value, so a design that
  // looks at them without the valid pulse sees a wrong address rather than a lucky match.
  task automatic send(input int ch, input logic [47:0] dest, input logic [3:0] msg);
    begin
      @(posedge aclk);
      frame_valid[ch]    <= 1'b1;
      frame_dest[ch]     <= dest;
      frame_msg_type[ch] <= msg;
      @(posedge aclk);
      frame_valid[ch]    <= 1'b0;
      frame_dest[ch]     <= ~dest;
      frame_msg_type[ch] <= ~msg;
    end
  endtask
endmodule // ppaf_frame_src
`default_nettype wire
